// ===== dv/msfs_host_model.sv
/*
  Host-side partner of the monitor and status block: issues register writes,
  register reads and data-read byte requests, and notes the byte each read
  should return in rq and dq.
  Assumes the testbench pops those queues as the answers appear.
*/
`timescale 1ns/10ps
`default_nettype none

module msfs_host_model
  import msfs_pkg::*;
(
  input  wire logic              clk,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [7:0]        reg_wdata,
  output logic                   data_rd_req,
  output logic      [1:0]        data_rd_idx
);
  logic [7:0] rq[$];
  logic [7:0] dq[$];

  initial begin
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = '0;
    reg_wdata   = 8'h00;
    data_rd_req = 1'b0;
    data_rd_idx = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each strobe stands for one edge; address and data stay until the next use.
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rq.push_back(exp);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : reg_read

  task automatic data_read(input logic [1:0] i, input logic [7:0] exp);
    @(posedge clk);
    data_rd_idx <= i;
    data_rd_req <= 1'b1;
    dq.push_back(exp);
    @(posedge clk);
    data_rd_req <= 1'b0;
  endtask : data_read

endmodule : msfs_host_model
`default_nettype wire

// ===== dv/tb.sv
/*
  Self-checking bench of the monitor and status block with a host model.
  Assumes a 20 MHz clock and a shortened startup count.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import msfs_pkg::*;
  localparam int unsigned SU = 6;

  logic clk, arst_n, reg_wr, reg_rd, conv_start, conv_end, data_rd_req;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, data_rd_byte_q;
  logic [3:0] rail_fault_async;
  logic [1:0] ref_fault_async, data_rd_idx, burnout_source_q, amp_enable_q;
  logic [1:0] ref_detect_enable_q;
  logic [23:0] conv_result, res;
  logic [2:0] data_rd_len_q, gain_eff_q, m;
  logic done_n, ain, mid, temp, avm, dvm, rail_en, rail_adc, pull;
  logic [31:0] rnd;
  logic rd_seen, dr_seen;
  int bad_count, compares;

  msfs_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .data_rd_req(data_rd_req), .data_rd_idx(data_rd_idx));

  msfs_monitor_status #(.STARTUP_CYCLES(SU)) i_dut (.clk(clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .conv_start(conv_start), .conv_end(conv_end),
    .rail_fault_async(rail_fault_async), .ref_fault_async(ref_fault_async),
    .data_rd_req(data_rd_req), .data_rd_idx(data_rd_idx), .conv_result(conv_result),
    .data_rd_byte_q(data_rd_byte_q), .data_rd_len_q(data_rd_len_q),
    .conversion_done_n_q(done_n), .ain_connect_q(ain), .mid_short_q(mid),
    .temp_sense_sel_q(temp), .analog_supply_monitor_q(avm),
    .digital_supply_monitor_q(dvm), .burnout_source_q(burnout_source_q),
    .gain_eff_q(gain_eff_q), .amp_enable_q(amp_enable_q), .rail_mon_en_q(rail_en),
    .rail_sense_adc_q(rail_adc), .ref_detect_enable_q(ref_detect_enable_q),
    .ref_pull_res_q(pull));

  always #25 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk(16'(got), 16'(exp));
  endtask : chk_reg

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    chk(16'(got), 16'(exp));
  endtask : chk_data

  task automatic report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Answers come one edge after the request edge, so compare at the edge after.
  always @(posedge clk) begin
    if (rd_seen) begin
      if (i_host.rq.size() == 0) chk_reg(8'h00, 8'hFF);
      else chk_reg(reg_rdata_q, i_host.rq.pop_front());
    end
    if (dr_seen) begin
      if (i_host.dq.size() == 0) chk_data(8'h00, 8'hFF);
      else chk_data(data_rd_byte_q, i_host.dq.pop_front());
    end
    rd_seen <= reg_rd;
    dr_seen <= data_rd_req;
  end

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // Faults are pulsed early and removed, so a flag proves it was latched.
  task automatic conv(input logic [3:0] rf, input logic [1:0] ff, input logic [7:0] pre,
                      input logic [7:0] post);
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start       <= 1'b0;
    rail_fault_async <= rf;
    ref_fault_async  <= ff;
    repeat (4) @(posedge clk);
    rail_fault_async <= 4'h0;
    ref_fault_async  <= 2'h0;
    #1 chk(16'(done_n), 16'h0001);
    i_host.reg_read(ADDR_STATUS, pre);
    repeat (2) @(posedge clk);
    conv_end <= 1'b1;
    @(posedge clk);
    conv_end <= 1'b0;
    #1 chk(16'(done_n), 16'h0000);
    i_host.reg_read(ADDR_STATUS, post);
  endtask : conv

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0; arst_n = 1'b0; conv_start = 1'b0; conv_end = 1'b0;
    rail_fault_async = 4'h0; ref_fault_async = 2'h0; conv_result = 24'h000000;
    rnd = 32'h96B4; rd_seen = 1'b0; dr_seen = 1'b0; bad_count = 0; compares = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    i_host.reg_read(ADDR_STATUS, 8'h80);
    i_host.reg_write(ADDR_SYS_CTRL, 8'hE0);
    repeat (SU) @(posedge clk);
    i_host.reg_read(ADDR_SYS_CTRL, 8'h00);
    i_host.reg_read(ADDR_STATUS, 8'hC0);
    rnd = xs(rnd);
    i_host.reg_write(ADDR_STATUS, rnd[7:0] | 8'h80);
    i_host.reg_read(ADDR_STATUS, 8'hC0);
    i_host.reg_write(ADDR_STATUS, 8'h7F);
    i_host.reg_read(ADDR_STATUS, 8'h40);
    i_host.reg_read(5'h1F, 8'h00);
    // Gain code 2 is a gain of 4, low enough for the temperature reading.
    i_host.reg_write(ADDR_GAIN, 8'h0A);
    for (int c = 0; c < 8; c++) begin
      m = 3'(c);
      i_host.reg_write(ADDR_SYS_CTRL, {m, 5'h00});
      settle();
      chk(16'({ain, mid, temp, avm, dvm}), 16'({(m == 3'h0 || m >= 3'h5), m == 3'h1,
          m == 3'h2, m == 3'h3, m == 3'h4}));
      chk(16'(burnout_source_q), 16'((m >= 3'h5) ? m - 3'h4 : 3'h0));
      chk(16'(gain_eff_q), 16'((m == 3'h3 || m == 3'h4) ? 3'h0 : 3'h2));
      chk(16'(amp_enable_q), 16'h0001);
    end
    i_host.reg_read(ADDR_SYS_CTRL, 8'hE0);
    i_host.reg_write(ADDR_SYS_CTRL, 8'h00);
    i_host.reg_write(ADDR_EXC1, 8'h80);
    settle();
    chk(16'({rail_en, rail_adc}), 16'h0002);
    i_host.reg_write(ADDR_GAIN, 8'h02);
    settle();
    chk(16'(rail_adc), 16'h0001);
    rnd = xs(rnd);
    conv_result <= rnd[23:0];
    conv(rnd[3:0] | 4'h1, 2'h3, 8'h40, 8'h40 | {rnd[3:0] | 4'h1, 2'h0});
    conv(4'h0, 2'h0, 8'h40 | {rnd[3:0] | 4'h1, 2'h0}, 8'h40);
    i_host.reg_write(ADDR_EXC1, 8'h00);
    conv(4'hF, 2'h0, 8'h40, 8'h40);
    i_host.reg_write(ADDR_REF_CTRL, 8'hE0);
    settle();
    chk(16'({ref_detect_enable_q, pull}), 16'h0007);
    conv(4'h0, 2'h3, 8'h40, 8'h43);
    conv(4'h0, 2'h1, 8'h43, 8'h41);
    rnd = xs(rnd);
    res = rnd[23:0];
    conv_result <= res;
    for (int k = 0; k < 4; k++) begin
      i_host.data_read(2'(k), (k < 3) ? res[23 - 8 * k -: 8] : 8'h00);
    end
    chk(16'(data_rd_len_q), 16'h0003);
    i_host.reg_write(ADDR_SYS_CTRL, 8'h01);
    settle();
    chk(16'(data_rd_len_q), 16'h0004);
    i_host.data_read(2'h0, 8'h41);
    for (int k = 1; k < 4; k++) begin
      i_host.data_read(2'(k), res[31 - 8 * k -: 8]);
    end
    // A second reset in mid-run must raise the power-on flag again.
    repeat (2) @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    i_host.reg_read(ADDR_STATUS, 8'h80);
    i_host.reg_write(ADDR_SYS_CTRL, 8'h01);
    i_host.reg_read(ADDR_SYS_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    if (i_host.rq.size() != 0 || i_host.dq.size() != 0) bad_count++;
    report_and_stop();
  end

endmodule : tb
`default_nettype wire

// ===== inc/msfs_pkg.sv
/*
  Shared constants and types for the monitor-select and fault-status logic:
  register addresses, field positions, reset values, monitor-select codes and
  the startup timing.
  Assumes it is compiled before every design file that imports it.
*/
package msfs_pkg;

  // Register addresses on the register access port.
  localparam int unsigned ADDR_W        = 5;
  localparam logic [4:0]  ADDR_STATUS   = 5'h01;
  localparam logic [4:0]  ADDR_GAIN     = 5'h03;
  localparam logic [4:0]  ADDR_REF_CTRL = 5'h05;
  localparam logic [4:0]  ADDR_EXC1     = 5'h06;
  localparam logic [4:0]  ADDR_SYS_CTRL = 5'h09;

  // Status byte layout.
  localparam int unsigned ST_POR_BIT  = 7;
  localparam int unsigned ST_RDY_BIT  = 6;
  localparam int unsigned ST_RAIL_LSB = 2;
  localparam int unsigned ST_REF_LSB  = 0;
  localparam int unsigned RAIL_W      = 4;
  localparam int unsigned REF_W       = 2;

  // Field positions in the control registers.
  localparam int unsigned GAIN_LSB         = 0;
  localparam int unsigned AMP_EN_LSB       = 3;
  localparam int unsigned REF_DET_LSB      = 6;
  localparam int unsigned REF_PULL_BIT     = 5;
  localparam int unsigned EXC1_RAIL_EN_BIT = 7;
  localparam int unsigned SYS_MON_LSB      = 5;
  localparam int unsigned SYS_PREPEND_BIT  = 0;

  // Reset values of the control registers.
  localparam logic [7:0] RST_GAIN     = 8'h00;
  localparam logic [7:0] RST_REF_CTRL = 8'h00;
  localparam logic [7:0] RST_EXC1     = 8'h00;
  localparam logic [7:0] RST_SYS_CTRL = 8'h00;

  // Field encodings.
  localparam logic [2:0] GAIN_UNITY = 3'h0;
  localparam logic [1:0] AMP_BYPASS = 2'h0;
  localparam logic [1:0] BO_0P2UA   = 2'h1;
  localparam logic [1:0] BO_1UA     = 2'h2;
  localparam logic [1:0] BO_10UA    = 2'h3;
  localparam logic [1:0] BO_OFF     = 2'h0;

  typedef enum logic [2:0] {
    MON_NORMAL = 3'h0,
    MON_MID    = 3'h1,
    MON_TEMP   = 3'h2,
    MON_AVDD   = 3'h3,
    MON_DVDD   = 3'h4,
    MON_BO_LO  = 3'h5,
    MON_BO_MID = 3'h6,
    MON_BO_HI  = 3'h7
  } msfs_mon_t;

  // Startup time before configuration changes are accepted.
  localparam int unsigned CLK_KHZ     = 20000;
  localparam int unsigned STARTUP_US  = 2;
  localparam int unsigned STARTUP_CYC = (STARTUP_US * CLK_KHZ + 999) / 1000;

endpackage : msfs_pkg

// ===== verilog/msfs_flag_latch.sv
/*
  One group of fault flags: the comparator outputs are synchronised, any fault
  during a conversion is caught while en is high, and the visible flags change
  only at the end of that conversion.
  Assumes conv_end is a one-cycle pulse from logic on clk.
*/
`timescale 1ns/10ps
`default_nettype none

module msfs_flag_latch #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] fault_async,
  input  wire logic         conv_end,
  output logic      [W-1:0] flags_q
);

  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] acc_q;
  wire  [W-1:0] seen = sync2_q & {W{en}};

  initial begin
    if (W < 1) $error("msfs_flag_latch: W must be at least 1");
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= fault_async;
      sync2_q <= sync1_q;
    end
  end

  // The sample taken in the end cycle still belongs to the ending conversion.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q   <= '0;
      flags_q <= '0;
    end else if (conv_end) begin
      acc_q   <= '0;
      flags_q <= acc_q | seen;
    end else begin
      acc_q   <= acc_q | seen;
    end
  end

  AST_FLAGS_AT_END: assert property (@(posedge clk) disable iff (!arst_n)
    conv_end |=> flags_q == ($past(acc_q) | $past(seen)))
    else $error("flags did not take the caught faults at conversion end");

  AST_FLAGS_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !conv_end |=> $stable(flags_q))
    else $error("flags changed outside a conversion end");

endmodule : msfs_flag_latch

`default_nettype wire

// ===== verilog/msfs_monitor_status.sv
/*
  Monitor-select routing and fault status byte of the converter.
  Holds the control registers that steer the monitor paths and the status byte
  with its power-on, ready, rail and reference flags; builds the byte sequence
  of a conversion data read.
  Assumes a register access port on clk, comparator outputs from the analog
  side that are asynchronous, and conversion start/end pulses on clk.
*/
// How it works
// - Select code 010 routes the temperature sensor to the converter.
// - Temperature readings keep programmed gain, rate and reference.
// - Code 011 routes analog supply monitor, code 100 digital supply monitor.
// - Supply monitors present supply difference divided by four.
// - Supply monitors disconnect inputs and force gain 1; amp mode stays free.
// - Codes 101, 110, 111 enable burn-out sources at 0.2, 1, 10 uA.
// - Burn-out sources feed positive input and drain negative input together.
// - Eight-bit fault status byte is readable at address 01h.
// - With prepend enabled the status byte leads every data read.
// - Status read returns flags caught in last completed conversion.
// - Power-on reset sets bit 7; host clears it by writing 0.
// - Bit 6 shows startup finished; not ready while registers reinitialise.
// - Bits 5 to 2 are the four amplifier rail flags.
// - Rail faults are caught only while their enable bit is set.
// - With amplifier bypassed the rail monitors sense the converter input.
// - Rail faults are caught during conversion, shown at its end.
// - Bit 0 flags reference below 300 mV, bit 1 below third of supply.
// - Reference detection works only when its two-bit field enables it.
// - Reference flags caught per conversion, updated as data-ready falls.
// - Selectable pull-together resistor across the reference pair.
// - Code 001 shorts the converter input to mid-scale.
`timescale 1ns/10ps
`default_nettype none

module msfs_monitor_status
  import msfs_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata_q,
  input  wire logic              conv_start,
  input  wire logic              conv_end,
  input  wire logic [RAIL_W-1:0] rail_fault_async,
  input  wire logic [REF_W-1:0]  ref_fault_async,
  input  wire logic              data_rd_req,
  input  wire logic [1:0]        data_rd_idx,
  input  wire logic [23:0]       conv_result,
  output logic      [7:0]        data_rd_byte_q,
  output logic      [2:0]        data_rd_len_q,
  output logic                   conversion_done_n_q,
  output logic                   ain_connect_q,
  output logic                   mid_short_q,
  output logic                   temp_sense_sel_q,
  output logic                   analog_supply_monitor_q,
  output logic                   digital_supply_monitor_q,
  output logic      [1:0]        burnout_source_q,
  output logic      [2:0]        gain_eff_q,
  output logic      [1:0]        amp_enable_q,
  output logic                   rail_mon_en_q,
  output logic                   rail_sense_adc_q,
  output logic      [1:0]        ref_detect_enable_q,
  output logic                   ref_pull_res_q
);

  initial begin
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535)
      $error("msfs_monitor_status: STARTUP_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup sequencing.

  typedef enum logic [1:0] {
    SU_INIT  = 2'b01,
    SU_READY = 2'b10
  } msfs_su_t;

  msfs_su_t    su_q;
  msfs_su_t    su_d;
  logic [15:0] su_cnt_q;
  wire         su_done = (su_cnt_q == 16'(STARTUP_CYCLES - 1));
  wire         ready   = (su_q == SU_READY);

  always_comb begin
    su_d = su_q;
    unique case (su_q)
      SU_INIT:  if (su_done) su_d = SU_READY;
      SU_READY: su_d = SU_READY;
      default:  su_d = SU_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      su_q     <= SU_INIT;
      su_cnt_q <= 16'h0000;
    end else begin
      su_q     <= su_d;
      su_cnt_q <= (su_q == SU_INIT) ? su_cnt_q + 16'h0001 : su_cnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers. Writes are dropped until startup is over, since the
  // map is still being brought to its reset values then.

  logic [7:0] gain_reg_q;
  logic [7:0] ref_ctrl_q;
  logic [7:0] exc1_q;
  logic [7:0] sys_ctrl_q;
  logic       por_flag_q;

  wire wr_ok      = reg_wr && ready;
  wire wr_gain    = wr_ok && (reg_addr == ADDR_GAIN);
  wire wr_ref     = wr_ok && (reg_addr == ADDR_REF_CTRL);
  wire wr_exc1    = wr_ok && (reg_addr == ADDR_EXC1);
  wire wr_sys     = wr_ok && (reg_addr == ADDR_SYS_CTRL);
  wire wr_status  = wr_ok && (reg_addr == ADDR_STATUS);
  wire por_clear  = wr_status && !reg_wdata[ST_POR_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_reg_q <= RST_GAIN;
      ref_ctrl_q <= RST_REF_CTRL;
      exc1_q     <= RST_EXC1;
      sys_ctrl_q <= RST_SYS_CTRL;
    end else begin
      if (wr_gain) gain_reg_q <= reg_wdata;
      if (wr_ref)  ref_ctrl_q <= reg_wdata;
      if (wr_exc1) exc1_q     <= reg_wdata;
      if (wr_sys)  sys_ctrl_q <= reg_wdata;
    end
  end

  // Only the asynchronous reset arst_n sets the flag, so no set can meet a clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) por_flag_q <= 1'b1;
    else if (por_clear) por_flag_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor routing decode.

  wire [2:0] mon_sel   = sys_ctrl_q[SYS_MON_LSB +: 3];
  wire [2:0] gain_prog = gain_reg_q[GAIN_LSB +: 3];
  wire [1:0] amp_prog  = gain_reg_q[AMP_EN_LSB +: 2];
  wire       sel_temp  = (mon_sel == MON_TEMP);
  wire       sel_avdd  = (mon_sel == MON_AVDD);
  wire       sel_dvdd  = (mon_sel == MON_DVDD);
  wire       sel_supp  = sel_avdd || sel_dvdd;
  wire       sel_mid   = (mon_sel == MON_MID);
  wire       sel_norm  = (mon_sel == MON_NORMAL);
  // Inputs stay connected for burn-out checks: the sources act on them.
  wire       ain_on    = !(sel_temp || sel_supp || sel_mid);
  // Temperature readings keep the programmed gain; only supplies force 1.
  wire [2:0] gain_eff  = sel_supp ? GAIN_UNITY : gain_prog;
  wire [1:0] bo_level  = (mon_sel == MON_BO_LO)  ? BO_0P2UA :
                         (mon_sel == MON_BO_MID) ? BO_1UA   :
                         (mon_sel == MON_BO_HI)  ? BO_10UA  : BO_OFF;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ain_connect_q            <= 1'b1;
      mid_short_q              <= 1'b0;
      temp_sense_sel_q         <= 1'b0;
      analog_supply_monitor_q  <= 1'b0;
      digital_supply_monitor_q <= 1'b0;
      burnout_source_q         <= BO_OFF;
      gain_eff_q               <= GAIN_UNITY;
      amp_enable_q             <= AMP_BYPASS;
    end else begin
      ain_connect_q            <= ain_on || sel_norm;
      mid_short_q              <= sel_mid;
      temp_sense_sel_q         <= sel_temp;
      analog_supply_monitor_q  <= sel_avdd;
      digital_supply_monitor_q <= sel_dvdd;
      // One level drives both the source on the positive input and the sink
      // on the negative input, so they can never be out of step.
      burnout_source_q         <= bo_level;
      gain_eff_q               <= gain_eff;
      amp_enable_q             <= amp_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault monitors.

  wire       rail_en    = exc1_q[EXC1_RAIL_EN_BIT];
  wire [1:0] ref_det    = ref_ctrl_q[REF_DET_LSB +: 2];
  wire       ref_en     = (ref_det != 2'h0);
  logic [RAIL_W-1:0] rail_flags;
  logic [REF_W-1:0]  ref_flags;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rail_mon_en_q       <= 1'b0;
      rail_sense_adc_q    <= 1'b1;
      ref_detect_enable_q <= 2'h0;
      ref_pull_res_q      <= 1'b0;
    end else begin
      rail_mon_en_q       <= rail_en;
      rail_sense_adc_q    <= (amp_prog == AMP_BYPASS);
      ref_detect_enable_q <= ref_det;
      ref_pull_res_q      <= ref_ctrl_q[REF_PULL_BIT];
    end
  end

  // Rail order on the bus: pos high, pos low, neg high, neg low, from bit 3.
  msfs_flag_latch #(
    .W (RAIL_W)
  ) u_rail (
    .clk         (clk),
    .arst_n      (arst_n),
    .en          (rail_en),
    .fault_async (rail_fault_async),
    .conv_end    (conv_end),
    .flags_q     (rail_flags)
  );

  // Bit 1 is the one-third-supply threshold, bit 0 the 300 mV threshold.
  msfs_flag_latch #(
    .W (REF_W)
  ) u_ref (
    .clk         (clk),
    .arst_n      (arst_n),
    .en          (ref_en),
    .fault_async (ref_fault_async),
    .conv_end    (conv_end),
    .flags_q     (ref_flags)
  );

  // Data-ready falls on the same edge that updates the flags.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) conversion_done_n_q <= 1'b1;
    else if (conv_end) conversion_done_n_q <= 1'b0;
    else if (conv_start) conversion_done_n_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte, register reads and data reads.

  wire [7:0] status_byte = {por_flag_q, ready, rail_flags, ref_flags};
  wire       prepend     = sys_ctrl_q[SYS_PREPEND_BIT];

  wire [7:0] reg_rd_mux =
    (reg_addr == ADDR_STATUS)   ? status_byte :
    (reg_addr == ADDR_GAIN)     ? gain_reg_q  :
    (reg_addr == ADDR_REF_CTRL) ? ref_ctrl_q  :
    (reg_addr == ADDR_EXC1)     ? exc1_q      :
    (reg_addr == ADDR_SYS_CTRL) ? sys_ctrl_q  : 8'h00;

  wire [1:0] res_idx = prepend ? (data_rd_idx - 2'h1) : data_rd_idx;
  wire [7:0] res_byte = (res_idx == 2'h0) ? conv_result[23:16] :
                        (res_idx == 2'h1) ? conv_result[15:8]  :
                        (res_idx == 2'h2) ? conv_result[7:0]   : 8'h00;
  wire [7:0] data_mux = (prepend && data_rd_idx == 2'h0) ? status_byte
                                                         : res_byte;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q    <= 8'h00;
      data_rd_byte_q <= 8'h00;
      data_rd_len_q  <= 3'h3;
    end else begin
      if (reg_rd)      reg_rdata_q    <= reg_rd_mux;
      if (data_rd_req) data_rd_byte_q <= data_mux;
      data_rd_len_q <= prepend ? 3'h4 : 3'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_status_read;
    reg_rd && reg_addr == ADDR_STATUS;
  endsequence

  AST_TEMP_ROUTE: assert property (@(posedge clk) disable iff (!arst_n)
    sel_temp |=> temp_sense_sel_q && !ain_connect_q)
    else $error("temperature sensor not routed");

  AST_TEMP_GAIN: assert property (@(posedge clk) disable iff (!arst_n)
    sel_temp |=> gain_eff_q == $past(gain_prog))
    else $error("temperature reading changed the gain");

  AST_SUPPLY: assert property (@(posedge clk) disable iff (!arst_n)
    sel_supp |=> gain_eff_q == GAIN_UNITY && !ain_connect_q
                 && amp_enable_q == $past(amp_prog))
    else $error("supply monitor did not force unity gain");

  AST_BURNOUT: assert property (@(posedge clk) disable iff (!arst_n)
    mon_sel == MON_BO_HI |=> burnout_source_q == BO_10UA)
    else $error("burn-out level wrong");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (!arst_n)
    s_status_read |=> reg_rdata_q == $past(status_byte))
    else $error("status read returned wrong byte");

  AST_PREPEND: assert property (@(posedge clk) disable iff (!arst_n)
    data_rd_req && prepend && data_rd_idx == 2'h0 |=> data_rd_byte_q == $past(status_byte))
    else $error("status byte not first in data read");

  AST_POR_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    por_flag_q && !por_clear |=> por_flag_q)
    else $error("power-on flag dropped without a clear");

  AST_READY: assert property (@(posedge clk) disable iff (!arst_n)
    !ready |-> !status_byte[ST_RDY_BIT] && !wr_sys)
    else $error("ready shown or write taken during startup");

  AST_RAIL_EN: assert property (@(posedge clk) disable iff (!arst_n)
    !rail_en [*3] ##1 conv_end |=> rail_flags == '0)
    else $error("rail flags reported while disabled");

  AST_CONVERSION_DONE_N_FLAGS: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(conversion_done_n_q) |-> $past(conv_end))
    else $error("data-ready fell without a conversion end");

  AST_MID_SHORT: assert property (@(posedge clk) disable iff (!arst_n)
    sel_mid |=> mid_short_q && !ain_connect_q && !temp_sense_sel_q)
    else $error("mid-scale short not applied");

  AST_NORMAL: assert property (@(posedge clk) disable iff (!arst_n)
    sel_norm |=> ain_connect_q && !mid_short_q && !temp_sense_sel_q
                 && burnout_source_q == BO_OFF)
    else $error("normal input path not restored");

  AST_DVDD: assert property (@(posedge clk) disable iff (!arst_n)
    sel_dvdd |=> digital_supply_monitor_q && !analog_supply_monitor_q)
    else $error("digital supply monitor not routed");

  AST_BO_LOW: assert property (@(posedge clk) disable iff (!arst_n)
    mon_sel == MON_BO_LO |=> burnout_source_q == BO_0P2UA && ain_connect_q)
    else $error("low burn-out level wrong");

  // Bypass keeps the rail monitors alive, so they must follow the input node.
  AST_RAIL_SENSE: assert property (@(posedge clk) disable iff (!arst_n)
    amp_prog == AMP_BYPASS |=> rail_sense_adc_q)
    else $error("rail monitor not moved to the converter input in bypass");

endmodule : msfs_monitor_status

`default_nettype wire
